// file: bench/i2c_irq_flag_logic_bench.sv
// bench of the bus event flag block: bus peer, register traffic, answer queue
`timescale 1ns/1ns
`include "i2cirq_regs.vh"
module i2c_irq_flag_logic_bench;
    localparam [4:0] CT = `I2CIRQ_CTRL_OFS, ST = `I2CIRQ_STAT_OFS, MD = `I2CIRQ_MODE_OFS;
    reg clk_sys = 1'b0, nrst = 1'b0, clk_en = 1'b1, arb_lost_evt = 1'b0, tx_buf_write = 1'b0;
    reg [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    reg [31:0] s_axi_wdata = 32'h0, rv;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire irq, scl_hold, tx_buf_empty_flag, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, peer_scl, sda_in;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    // wired-and clock line: the block holds it low during a wait
    wire scl_in = peer_scl & ~scl_hold;
    integer n_fail = 0, cmp_count = 0, seed = 32'h388a, i;
    reg [65:0] exp_q[$];
    reg [65:0] rx;
    reg [1:0] last_b;
    i2cirq_top i2cirq_top_inst (.*);
    i2cirq_peer i2cirq_peer_inst (.scl(peer_scl), .sda(sda_in), .hold(scl_hold));
    always #20 clk_sys = ~clk_sys;
    // ==========================================
    // shared tasks
    task cmp(input [31:0] got, input [31:0] want);
        begin
            cmp_count = cmp_count + 1;
            if (got !== want)
            begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t: got %h want %h", $time, got, want);
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] v);
        reg ra, rw, rb;
        begin
            @(posedge clk_sys);
            rv = $random(seed);
            s_axi_awaddr <= a;
            s_axi_wdata <= {rv[31:8], v};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            rb = 1'b0;
            while (!rb)
            begin
                @(negedge clk_sys);
                ra = s_axi_awready;
                rw = s_axi_wready;
                rb = s_axi_bvalid;
                last_b = s_axi_bresp;
                @(posedge clk_sys);
                if (ra) s_axi_awvalid <= 1'b0;
                if (rw) s_axi_wvalid <= 1'b0;
                if (rb) s_axi_bready <= 1'b0;
            end
        end
    endtask
    // the expectation is queued before the request goes out
    task rd(input [4:0] a, input [31:0] m, input [31:0] e, input [1:0] r);
        reg ra, rr;
        begin
            @(posedge clk_sys);
            exp_q.push_back({r, m, e});
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            rr = 1'b0;
            while (!rr)
            begin
                @(negedge clk_sys);
                ra = s_axi_arready;
                rr = s_axi_rvalid;
                @(posedge clk_sys);
                if (ra) s_axi_arvalid <= 1'b0;
                if (rr) s_axi_rready <= 1'b0;
            end
        end
    endtask
    // arm by reading the flag set (when m), then write 0 to it
    task clr(input [7:0] c, input m);
        begin
            rd(CT, 32'h2, {30'h0, m, 1'b0}, 2'b00);
            wr(CT, c);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task close_out;
        begin
            $display("compares %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // answer watcher: oldest note against each read answer
    always @(negedge clk_sys)
    begin
        if (s_axi_rvalid && s_axi_rready)
        begin
            rx = exp_q.pop_front();
            cmp(s_axi_rdata & rx[63:32], rx[31:0]);
            cmp({30'h0, s_axi_rresp}, {30'h0, rx[65:64]});
        end
    end
    // watchdog: a hang counts as a mismatch
    initial
    begin
        #1000000;
        n_fail = n_fail + 1;
        close_out;
    end
    // ==========================================
    // main sequence
    initial
    begin
        tick(6);
        nrst <= 1'b1;
        tick(4);
        rd(CT, 32'hff, 32'h0, 2'b00);
        rd(ST, 32'h1ff, 32'h0, 2'b00);
        rd(5'h14, 32'hffffffff, 32'h0, 2'b10);
        wr(5'h18, 8'h01);
        cmp({30'h0, last_b}, 32'h2);
        wr(CT, 8'h0d);
        i2cirq_peer_inst.start;
        tick(10);
        rd(CT, 32'hff, 32'h0f, 2'b00);
        rd(ST, 32'h80, 32'h80, 2'b00);
        @(negedge clk_sys);
        cmp({31'h0, irq}, 32'h1);
        wr(CT, 8'h0f);
        wr(CT, 8'h0d);
        rd(CT, 32'hff, 32'h0f, 2'b00);
        clr(8'h0d, 1'b1);
        rd(CT, 32'hff, 32'h0d, 2'b00);
        @(posedge clk_sys);
        tx_buf_write <= 1'b1;
        @(posedge clk_sys);
        tx_buf_write <= 1'b0;
        rd(ST, 32'h80, 32'h0, 2'b00);
        i2cirq_peer_inst.stop;
        tick(10);
        rd(ST, 32'h20, 32'h20, 2'b00);
        clr(8'h0d, 1'b1);
        wr(ST, 8'hff);
        wr(CT, 8'h1d);
        @(posedge clk_sys);
        arb_lost_evt <= 1'b1;
        @(posedge clk_sys);
        arb_lost_evt <= 1'b0;
        rd(CT, 32'hff, 32'h1b, 2'b00);
        rd(ST, 32'h10, 32'h10, 2'b00);
        clr(8'h19, 1'b1);
        wr(ST, 8'hff);
        wr(`I2CIRQ_OWN_OFS, 8'h54);
        wr(`I2CIRQ_SEC_OFS, 8'h01);
        wr(MD, 8'h00);
        i2cirq_peer_inst.start;
        i2cirq_peer_inst.send_byte(8'h54, 1'b1);
        tick(10);
        rd(ST, 32'h07, 32'h03, 2'b00);
        clr(8'h19, 1'b1);
        wr(ST, 8'hff);
        i2cirq_peer_inst.send_byte(rv[7:0], 1'b0);
        tick(10);
        rd(ST, 32'h01, 32'h0, 2'b00);
        clr(8'h19, 1'b1);
        i2cirq_peer_inst.stop;
        tick(10);
        clr(8'h21, 1'b1);
        wr(ST, 8'hff);
        i2cirq_peer_inst.start;
        i2cirq_peer_inst.send_byte(8'h54, 1'b1);
        tick(10);
        rd(ST, 32'h03, 32'h02, 2'b00);
        clr(8'h21, 1'b1);
        i2cirq_peer_inst.stop;
        tick(10);
        rd(CT, 32'h02, 32'h0, 2'b00);
        rd(ST, 32'h20, 32'h20, 2'b00);
        wr(MD, 8'h01);
        wr(CT, 8'h01);
        i2cirq_peer_inst.start;
        tick(10);
        clr(8'h01, 1'b0);
        fork
            i2cirq_peer_inst.send_byte(8'h54, 1'b0);
        join_none
        for (i = 0; i < 400 && scl_hold !== 1'b1; i = i + 1) @(negedge clk_sys);
        cmp({31'h0, scl_hold}, 32'h1);
        cmp({31'h0, irq}, 32'h1);
        clr(8'h01, 1'b1);
        tick(4);
        @(negedge clk_sys);
        cmp({31'h0, scl_hold}, 32'h0);
        wait fork;
        i2cirq_peer_inst.stop;
        tick(10);
        clr(8'h01, 1'b1);
        wr(MD, 8'h00);
        wr(ST, 8'hff);
        i2cirq_peer_inst.start;
        i2cirq_peer_inst.send_byte(8'h00, 1'b0);
        tick(10);
        rd(ST, 32'h08, 32'h08, 2'b00);
        clr(8'h01, 1'b1);
        i2cirq_peer_inst.send_byte(rv[15:8], 1'b0);
        tick(10);
        clr(8'h01, 1'b1);
        i2cirq_peer_inst.stop;
        tick(10);
        close_out;
    end
endmodule // i2c_irq_flag_logic_bench

// file: bench/i2cirq_chk.sv
// port checks of the bus event flag block
`timescale 1ns/1ns
module i2cirq_chk (
    input wire clk_sys,
    input wire nrst,
    input wire irq,
    input wire scl_hold,
    input wire tx_buf_write,
    input wire tx_buf_empty_flag,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    // ==========================================
    // write traffic, the only way the flag may fall
    wire tk = (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid) else $error("write answer late");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_RD_UNMAP: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] > 3'h4
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read answer");
    AST_TXE_CLR: assert property (tx_buf_write |=> !tx_buf_empty_flag)
        else $error("buffer empty flag kept");
    AST_HOLD_SCL: assert property (scl_hold && !tk && !$past(tk) |=> scl_hold)
        else $error("clock hold released alone");
    AST_IRQ_HOLD: assert property (irq && !tk && !$past(tk) |=> irq)
        else $error("request fell without a write");
    COV_IRQ: cover property ($rose(irq));
    COV_HOLD: cover property ($rose(scl_hold));
    COV_UNMAP: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // i2cirq_chk
bind i2cirq_top i2cirq_chk i2cirq_chk_inst (.*);

// file: bench/i2cirq_peer.sv
// bus peer driving the clock and data lines of the two-wire bus
`timescale 1ns/1ns
module i2cirq_peer (
    output reg scl,
    output reg sda,
    input wire hold
);
    localparam HALF = 160;
    // ==========================================
    // idle lines sit at the pull-up level
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task start;
        begin
            sda = 1'b0;
            #HALF scl = 1'b0;
            #HALF;
        end
    endtask
    // data moves while clock low; a held clock is waited out
    task bit_out(input b, input slow);
        begin
            sda = b;
            #(HALF * (slow ? 3 : 1));
            while (hold) #20;
            scl = 1'b1;
            #HALF scl = 1'b0;
        end
    endtask
    // msb first, ninth clock carries the acknowledge
    task send_byte(input [7:0] d, input ack);
        integer k;
        begin
            for (k = 7; k >= 0; k = k - 1) bit_out(d[k], 1'b0);
            bit_out(ack, 1'b1);
            #40 sda = 1'b1;
        end
    endtask
    task stop;
        begin
            sda = 1'b0;
            #HALF scl = 1'b1;
            #HALF sda = 1'b1;
            #HALF;
        end
    endtask
endmodule // i2cirq_peer

// file: src/i2cirq_flag.v
// one sticky status bit where a hardware set beats a clear
`timescale 1ns/1ns
module i2cirq_flag (
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    input wire set,
    input wire clr,
    output reg q_reg
);
    // ==========================================
    // set has priority so no event is dropped
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            q_reg <= 1'b0;
        else if (clk_en)
        begin
            if (set)
                q_reg <= 1'b1;
            else if (clr)
                q_reg <= 1'b0;
        end
    end
endmodule // i2cirq_flag

// file: src/i2cirq_regs.vh
// register offsets, field positions, reset values and counts of the bus event flag block
`ifndef I2CIRQ_REGS_VH
`define I2CIRQ_REGS_VH
// ==========================================
// register byte offsets
`define I2CIRQ_CTRL_OFS 5'h00
`define I2CIRQ_STAT_OFS 5'h04
`define I2CIRQ_MODE_OFS 5'h08
`define I2CIRQ_OWN_OFS 5'h0c
`define I2CIRQ_SEC_OFS 5'h10
// ==========================================
// control register fields
`define I2CIRQ_CTRL_IRQ_EN 0
`define I2CIRQ_CTRL_FLAG 1
`define I2CIRQ_CTRL_MST 2
`define I2CIRQ_CTRL_ACK_CHECK_ENABLE 3
`define I2CIRQ_CTRL_ARB_LOSS_IRQ_ENABLE 4
`define I2CIRQ_CTRL_RELEASE_IRQ_MASK 5
`define I2CIRQ_CTRL_RST 8'h00
// ==========================================
// status register fields
`define I2CIRQ_ST_RECEIVED_ACK_BIT 0
`define I2CIRQ_ST_OWN 1
`define I2CIRQ_ST_SEC 2
`define I2CIRQ_ST_GCALL 3
`define I2CIRQ_ST_AL 4
`define I2CIRQ_ST_STOP 5
`define I2CIRQ_ST_ERROR_RELEASE_SEEN 6
`define I2CIRQ_ST_TXE 7
`define I2CIRQ_ST_BUSY 8
`define I2CIRQ_ST_W 9
// ==========================================
// mode and address register fields
`define I2CIRQ_MODE_WAIT 0
`define I2CIRQ_ADDR_FS 0
`define I2CIRQ_ADDR_RST 8'h00
`define I2CIRQ_GCALL_ADDR 7'h00
// ==========================================
// transfer clock counts within one byte, and register port response codes
`define I2CIRQ_DATA_CLKS 4'h8
`define I2CIRQ_ACK_CLK 4'h9
`define I2CIRQ_RESP_OK 2'b00
`define I2CIRQ_RESP_ERR 2'b10
`endif

// file: src/i2cirq_sync.v
// three-stage input synchroniser with two-stage agreement filter
`timescale 1ns/1ns
module i2cirq_sync #(
    parameter RESET_LEVEL = 1'b1
) (
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    input wire pin_in,
    output reg level_reg
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // ==========================================
    // first stage feeds only the second stage
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= RESET_LEVEL;
            s2_reg <= RESET_LEVEL;
            s3_reg <= RESET_LEVEL;
            level_reg <= RESET_LEVEL;
        end
        else if (clk_en)
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // a change counts once stages two and three agree
            if (s2_reg == s3_reg)
                level_reg <= s3_reg;
        end
    end
endmodule // i2cirq_sync

// file: src/i2cirq_top.v
// bus event request flag logic of a two-wire serial interface, with an AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "i2cirq_regs.vh"

// Overview of operation
// - request flag is control bit 1, reset 0
// - clear by reading 1 then writing 0
// - set timing follows format bits and wait bit
// - master start seen sets flag, buffer empty
// - wait enabled: set on eighth clock fall
// - no wait: set on ninth clock rise
// - after arbitration loss, set on address receipt
// - ack check and ack 1: set both
// - ack check off: ignore ack, bit 0
// - arbitration loss with enable sets flag too
// - slave address match sets flag, each byte
// - general call write sets flag, each byte
// - unmasked stop or error stop sets flag
module i2cirq_top (
    input wire clk_sys,
    input wire nrst,
    input wire clk_en,
    input wire scl_in,
    input wire sda_in,
    input wire arb_lost_evt,
    input wire tx_buf_write,
    output wire irq,
    output wire scl_hold,
    output wire tx_buf_empty_flag,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // ==========================================
    // reset release
    reg rst_a_reg;
    reg rst_n;
    // external reset is released through two stages
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_a_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_a_reg <= 1'b1;
            rst_n <= rst_a_reg;
        end
    end

    // ==========================================
    // bus line sampling
    wire scl_lvl;
    wire sda_lvl;
    reg scl_d_reg;
    reg sda_d_reg;
    i2cirq_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(scl_in),
        .level_reg(scl_lvl)
    );
    i2cirq_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(sda_in),
        .level_reg(sda_lvl)
    );
    // previous filtered levels for edge finding
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            scl_d_reg <= scl_lvl;
            sda_d_reg <= sda_lvl;
        end
    end
    wire scl_rise = scl_lvl & ~scl_d_reg;
    wire scl_fall = ~scl_lvl & scl_d_reg;
    wire start_det = scl_lvl & scl_d_reg & sda_d_reg & ~sda_lvl;
    wire stop_det = scl_lvl & scl_d_reg & ~sda_d_reg & sda_lvl;

    // ==========================================
    // software registers
    reg [7:0] ctrl_reg;
    reg [7:0] mode_reg;
    reg [7:0] own_addr_reg;
    reg [7:0] second_addr_reg;
    wire bus_event_request_flag;
    wire irq_enable = ctrl_reg[`I2CIRQ_CTRL_IRQ_EN];
    wire mst = ctrl_reg[`I2CIRQ_CTRL_MST];
    wire ack_check_enable = ctrl_reg[`I2CIRQ_CTRL_ACK_CHECK_ENABLE];
    wire arb_loss_irq_enable = ctrl_reg[`I2CIRQ_CTRL_ARB_LOSS_IRQ_ENABLE];
    wire release_irq_mask = ctrl_reg[`I2CIRQ_CTRL_RELEASE_IRQ_MASK];
    wire wait_enable = mode_reg[`I2CIRQ_MODE_WAIT];
    wire format_select_primary = own_addr_reg[`I2CIRQ_ADDR_FS];
    wire format_select_second = second_addr_reg[`I2CIRQ_ADDR_FS];
    wire [6:0] own_slave_addr = own_addr_reg[7:1];
    wire [6:0] second_slave_addr = second_addr_reg[7:1];
    // both format bits set selects the clocked serial format
    wire serial_fmt = format_select_primary & format_select_second;

    // ==========================================
    // byte framing on the bus
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg first_frame_reg;
    reg addressed_reg;
    reg lost_pend_reg;
    reg busy_reg;
    wire clk8_rise = scl_rise & (bit_cnt_reg == (`I2CIRQ_DATA_CLKS - 4'h1));
    wire clk8_fall = scl_fall & (bit_cnt_reg == `I2CIRQ_DATA_CLKS);
    wire clk9_rise = scl_rise & (bit_cnt_reg == `I2CIRQ_DATA_CLKS);
    wire clk9_fall = scl_fall & (bit_cnt_reg == `I2CIRQ_ACK_CLK);
    wire [7:0] addr_byte = {shift_reg[6:0], sda_lvl};
    wire in_frame = busy_reg & (bit_cnt_reg > 4'h1); // the release's own clock rise counts one

    // address decode of the first frame, seen at the eighth rise
    wire own_hit = first_frame_reg & clk8_rise & ~serial_fmt & ~format_select_primary
        & (addr_byte[7:1] == own_slave_addr);
    wire sec_hit = first_frame_reg & clk8_rise & ~serial_fmt & ~format_select_second
        & (addr_byte[7:1] == second_slave_addr) & ~own_hit;
    wire gcall_hit = first_frame_reg & clk8_rise & ~serial_fmt & ~mst
        & (addr_byte[7:1] == `I2CIRQ_GCALL_ADDR) & ~addr_byte[0];

    // bit count, shifting, frame and addressing state
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            first_frame_reg <= 1'b0;
            addressed_reg <= 1'b0;
            lost_pend_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start_det)
            begin
                bit_cnt_reg <= 4'h0;
                first_frame_reg <= 1'b1;
                addressed_reg <= 1'b0;
                busy_reg <= 1'b1;
            end
            else if (stop_det)
            begin
                bit_cnt_reg <= 4'h0;
                first_frame_reg <= 1'b0;
                addressed_reg <= 1'b0;
                lost_pend_reg <= 1'b0;
                busy_reg <= 1'b0;
            end
            else
            begin
                if (scl_rise)
                begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg < `I2CIRQ_DATA_CLKS)
                        shift_reg <= addr_byte;
                end
                else if (clk9_fall)
                begin
                    bit_cnt_reg <= 4'h0;
                    first_frame_reg <= 1'b0;
                end
                if (own_hit | sec_hit | gcall_hit)
                    addressed_reg <= 1'b1;
                // the lost-master wait ends with its first address frame
                if (arb_lost_evt)
                    lost_pend_reg <= 1'b1;
                else if (first_frame_reg & clk9_rise)
                    lost_pend_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // set conditions of the request flag
    // timing by format and wait bits
    wire pause_mode = wait_enable & ~serial_fmt;
    wire byte_owner = mst | addressed_reg | own_hit | sec_hit | gcall_hit;
    wire set_pause = pause_mode & clk8_fall & byte_owner;
    wire set_byte_end = ~serial_fmt & ~pause_mode & clk9_rise & byte_owner;
    // serial format ends its byte at the eighth rise
    wire set_serial = serial_fmt & (clk8_rise | start_det);
    // issued start seen on the lines
    wire set_start = mst & start_det & ~serial_fmt;
    wire set_lost_addr = lost_pend_reg & first_frame_reg & clk9_rise & ~serial_fmt;
    wire nack_evt = ack_check_enable & clk9_rise & sda_lvl & byte_owner & ~serial_fmt;
    wire set_al = arb_lost_evt & arb_loss_irq_enable;
    // stop or erroneous stop when unmasked
    wire error_release_seen_evt = stop_det & in_frame;
    wire set_stop = stop_det & ~release_irq_mask;
    // address matches flag at the frame end
    wire set_match = addressed_reg & first_frame_reg & (pause_mode ? clk8_fall : clk9_rise);
    wire flag_set = set_pause | set_byte_end | set_serial | set_start | set_lost_addr
        | nack_evt | set_al | set_stop | set_match;

    // ==========================================
    // AXI4-Lite write channel
    reg aw_held_reg;
    reg w_held_reg;
    reg [4:0] aw_addr_reg;
    reg [7:0] w_data_reg;
    reg w_strb_reg;
    reg clr_armed_reg;
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
    wire wr_go = aw_held_reg & w_held_reg;
    wire wr_ctrl = wr_go & w_strb_reg & (aw_addr_reg == `I2CIRQ_CTRL_OFS);
    wire wr_stat = wr_go & w_strb_reg & (aw_addr_reg == `I2CIRQ_STAT_OFS);
    wire wr_map = (aw_addr_reg == `I2CIRQ_CTRL_OFS) | (aw_addr_reg == `I2CIRQ_STAT_OFS)
        | (aw_addr_reg == `I2CIRQ_MODE_OFS) | (aw_addr_reg == `I2CIRQ_OWN_OFS)
        | (aw_addr_reg == `I2CIRQ_SEC_OFS);
    // a written 1 is ignored, 0 clears only after a read of 1
    wire flag_clr = wr_ctrl & clr_armed_reg & ~w_data_reg[`I2CIRQ_CTRL_FLAG];

    // address and data latch in either order, response after both
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `I2CIRQ_RESP_OK;
            ctrl_reg <= `I2CIRQ_CTRL_RST;
            mode_reg <= `I2CIRQ_CTRL_RST;
            own_addr_reg <= `I2CIRQ_ADDR_RST;
            second_addr_reg <= `I2CIRQ_ADDR_RST;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[4:2], 2'b00};
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `I2CIRQ_RESP_OK : `I2CIRQ_RESP_ERR;
                // flag bit is not stored here, it lives in its own flop
                if (wr_ctrl)
                    ctrl_reg <= w_data_reg & 8'hfd;
                if (w_strb_reg & (aw_addr_reg == `I2CIRQ_MODE_OFS))
                    mode_reg <= w_data_reg;
                if (w_strb_reg & (aw_addr_reg == `I2CIRQ_OWN_OFS))
                    own_addr_reg <= w_data_reg;
                if (w_strb_reg & (aw_addr_reg == `I2CIRQ_SEC_OFS))
                    second_addr_reg <= w_data_reg;
            end
            else if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // losing arbitration drops master mode
            if (arb_lost_evt)
                ctrl_reg[`I2CIRQ_CTRL_MST] <= 1'b0;
        end
    end

    // ==========================================
    // request flag and status flags
    // request flag, set beats clear
    i2cirq_flag u_req_flag (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .set(flag_set),
        .clr(flag_clr),
        .q_reg(bus_event_request_flag)
    );
    // status bits: ack, own, second, gcall, lost, stop, error stop, tx empty
    wire [7:0] st_set;
    wire [7:0] st_clr;
    wire [7:0] st_q;
    // ack bit only recorded with checking on
    assign st_set[`I2CIRQ_ST_RECEIVED_ACK_BIT] = nack_evt;
    assign st_set[`I2CIRQ_ST_OWN] = own_hit;
    assign st_set[`I2CIRQ_ST_SEC] = sec_hit;
    assign st_set[`I2CIRQ_ST_GCALL] = gcall_hit;
    assign st_set[`I2CIRQ_ST_AL] = arb_lost_evt;
    assign st_set[`I2CIRQ_ST_STOP] = stop_det & ~error_release_seen_evt;
    assign st_set[`I2CIRQ_ST_ERROR_RELEASE_SEEN] = error_release_seen_evt;
    // buffer empty set by the master start
    assign st_set[`I2CIRQ_ST_TXE] = set_start;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_st
            // write one to clear; ack bit also clears when checking is off
            assign st_clr[gi] = (wr_stat & w_data_reg[gi])
                | ((gi == `I2CIRQ_ST_RECEIVED_ACK_BIT) & ~ack_check_enable)
                | ((gi == `I2CIRQ_ST_TXE) & tx_buf_write)
                | ((gi == `I2CIRQ_ST_OWN || gi == `I2CIRQ_ST_SEC || gi == `I2CIRQ_ST_GCALL)
                   & (start_det | stop_det));
            i2cirq_flag u_st (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .set(st_set[gi]),
                .clr(st_clr[gi]),
                .q_reg(st_q[gi])
            );
        end
    endgenerate

    // ==========================================
    // AXI4-Lite read channel
    reg [31:0] rd_mux;
    reg rd_map;
    assign s_axi_arready = ~s_axi_rvalid;
    // read data selection, unmapped words read zero
    always @*
    begin
        rd_mux = 32'h00000000;
        rd_map = 1'b1;
        case ({s_axi_araddr[4:2], 2'b00})
            `I2CIRQ_CTRL_OFS: rd_mux[7:0] = ctrl_reg | {6'h00, bus_event_request_flag, 1'b0};
            `I2CIRQ_STAT_OFS: rd_mux[8:0] = {busy_reg, st_q};
            `I2CIRQ_MODE_OFS: rd_mux[7:0] = mode_reg;
            `I2CIRQ_OWN_OFS: rd_mux[7:0] = own_addr_reg;
            `I2CIRQ_SEC_OFS: rd_mux[7:0] = second_addr_reg;
            default: rd_map = 1'b0;
        endcase
    end
    wire rd_take = s_axi_arvalid & s_axi_arready;
    wire rd_ctrl = rd_take & ({s_axi_araddr[4:2], 2'b00} == `I2CIRQ_CTRL_OFS);
    // read answer one cycle after the address; arm clear on a read of 1
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `I2CIRQ_RESP_OK;
            clr_armed_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rd_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_map ? `I2CIRQ_RESP_OK : `I2CIRQ_RESP_ERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
            // clear armed only by reading the flag as 1
            if (rd_ctrl)
                clr_armed_reg <= bus_event_request_flag;
            else if (wr_ctrl)
                clr_armed_reg <= 1'b0;
        end
    end

    // ==========================================
    // outputs
    assign irq = bus_event_request_flag & irq_enable;
    // clock stretch while a pre-acknowledge wait is pending
    assign scl_hold = bus_event_request_flag & pause_mode & (bit_cnt_reg == `I2CIRQ_DATA_CLKS);
    assign tx_buf_empty_flag = st_q[`I2CIRQ_ST_TXE];
endmodule // i2cirq_top
